// >>> lrc_params.svh
// Constants for the system reset control of the segment display driver.
// Assumes inclusion by bare name from the package and the design file.
`ifndef LRC_PARAMS_SVH
`define LRC_PARAMS_SVH
// Serial frame layout: payload first, word index in the last bits sent.
`define LRC_WORD_W 42
`define LRC_WORDS 4
`define LRC_INDEX_W 3
`define LRC_FRAME_W 45
`define LRC_KEY_W 30
`define LRC_BITS_DUTY3 126
`define LRC_BITS_DUTY4 164
`define LRC_IDX_DISP_MAX 3'h3
`define LRC_IDX_CTRL 3'h4
`define LRC_IDX_KEYREAD 3'h7
// Control word field positions inside the payload.
`define LRC_CB_DUTY 0
`define LRC_CB_CLKSRC 1
`define LRC_CB_SCANOFF 2
`define LRC_CB_KSSEG 3
`define LRC_CB_GPO 4
`define LRC_GPO_W 4
// Control reset values.
`define LRC_DUTY_RST 1'b1
`define LRC_CLKSRC_RST 1'b0
// Pin groups and their bit positions in display word zero.
`define LRC_SEG_GPO_LO 0
`define LRC_SEG_DED_LO 4
`define LRC_SEG_DED_N 34
`define LRC_SEG_COM4 38
`define LRC_SEG_KS_LO 39
`define LRC_COM_N 3
`define LRC_KS_N 3
// Bus register map and fields.
`define LRC_ADDR_W 8
`define LRC_HSIZE_WORD 3'h2
`define LRC_OFS_STATUS 8'h00
`define LRC_OFS_KEYDATA 8'h04
`define LRC_OFS_CONFIG 8'h08
`define LRC_OFS_NONE 8'hff
`define LRC_ST_RESET 0
`define LRC_ST_DUTY 1
`define LRC_ST_CLKSRC 2
`define LRC_ST_DTKNOWN 3
`define LRC_ST_CTRL 4
`define LRC_ST_WORDS 5
`define LRC_ST_KEYREQ 9
`define LRC_CFG_INHIBIT 0
`endif

// >>> lrc_pkg.sv
// Types shared by the system reset control.
// Assumes the constants header is on the include path.
`default_nettype none
`include "lrc_params.svh"
package lrc_pkg;
    // Reset phase of the device; a single bit, so the codes are trivially Gray.
    typedef enum logic {
        LRC_RUNNING = 1'b0,
        LRC_HELD = 1'b1
    } lrc_phase_t;

    // State of the system clock domain, apart from the reset phase flop.
    typedef struct packed {
        logic enSync1;
        logic enSync2;
        logic enPrev;
        logic dropSync1;
        logic dropSync2;
        logic oscSync1;
        logic oscSync2;
        logic [`LRC_KEY_W-1:0] keySync1;
        logic [`LRC_KEY_W-1:0] keySync2;
        logic [`LRC_KEY_W-1:0] keyBuffer;
        logic keyRequest;
        logic [`LRC_WORDS-1:0] rxWords;
        logic rxCtrl;
        logic dutySelect;
        logic dtKnown;
        logic clockSourceSelect;
        logic keyScanDisable;
        logic keyscanSegMode;
        logic [`LRC_GPO_W-1:0] gpoMode;
        logic [`LRC_WORDS-1:0][`LRC_WORD_W-1:0] latch;
        logic scanInhibit;
        logic oscToggle;
        logic wrPending;
        logic [`LRC_ADDR_W-1:0] wrAddr;
        logic [31:0] rdata;
    } lrc_state_t;
endpackage
`default_nettype wire

// >>> lrc_reset_control.sv
// System reset control of a multiplexed segment display driver with key scan.
// Assumes a supply-drop detector output, a controller on the serial link and
// an AHB-Lite master for the status registers.
// Function
// (R1) Detector asserts reset during supply rise.
// (R2) Detector asserts reset during supply drop.
// (R3) Release only at enable fall completing set.
// (R4) Needed set: three or four words plus control.
// (R5) Reset stops oscillator or external clock.
// (R6) Display off; latch still takes data.
// (R7) Key scan reset and disabled.
// (R8) Key buffer cleared during reset.
// (R9) Serial side and control unaffected by reset.
// (R10) Shared segment pins forced segment, low.
// (R11) Dedicated segment, common, scan outputs low.
// (R12) Fourth common pin common before duty known.
// (R13) Duty bit selects fourth common pin function.
// (R14) Oscillator pin high impedance during reset.
// (R15) Key request released during reset.
// (R16) Clock select: zero RC, one external.
// (R17) Release turns display and scanning on.
// (R18) Pending key read pulls request low.
// (R19) Asynchronous assert, release at frame end.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_params.svh"

module lrc_reset_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic supplyDropResetDetect,
    input wire logic serialClock,
    input wire logic serialEnable,
    input wire logic serialData,
    input wire logic [`LRC_KEY_W-1:0] keyReturn,
    input wire logic oscPinIn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [`LRC_GPO_W-1:0] segGpoShared,
    output logic [`LRC_GPO_W-1:0] segGpoIsSegment,
    output logic [`LRC_SEG_DED_N-1:0] dedicatedSegmentOut,
    output logic [`LRC_COM_N-1:0] commonOut,
    output logic common4Seg39Shared,
    output logic common4IsCommon,
    output logic [`LRC_KS_N-1:0] keyscanSegShared,
    output logic keyscanIsSegment,
    output logic [`LRC_KS_N-1:0] keyscanOutDedicated,
    output logic oscPinOut,
    output logic oscPinOe,
    output logic oscRunEnable,
    output logic extClockEnable,
    output logic gatedExtClock,
    output logic keyRequestOut,
    output logic keyRequestOe,
    output logic systemReset,
    output logic displayOn,
    output logic keyScanEnabled
);

    // ************************************************************
    // Constants and helpers
    // ************************************************************

    localparam int WORDS3 = (`LRC_BITS_DUTY3 + `LRC_WORD_W - 1) / `LRC_WORD_W;
    localparam int WORDS4 = (`LRC_BITS_DUTY4 + `LRC_WORD_W - 1) / `LRC_WORD_W;
    localparam logic [`LRC_WORDS-1:0] MASK3 = `LRC_WORDS'((1 << WORDS3) - 1);
    localparam logic [`LRC_WORDS-1:0] MASK4 = `LRC_WORDS'((1 << WORDS4) - 1);

    // Display words that must have arrived before reset may end.
    function automatic logic [`LRC_WORDS-1:0] wordsNeeded(input logic duty4);
        wordsNeeded = duty4 ? MASK4 : MASK3; // R4
    endfunction

    // Register read decode; anything unmapped reads as zero.
    function automatic logic [31:0] readWord(
        input logic [`LRC_ADDR_W-1:0] addr,
        input lrc_pkg::lrc_state_t s,
        input logic rst
    );
        readWord = 32'h0;
        case (addr)
            `LRC_OFS_STATUS: begin
                readWord[`LRC_ST_RESET] = rst;
                readWord[`LRC_ST_DUTY] = s.dutySelect;
                readWord[`LRC_ST_CLKSRC] = s.clockSourceSelect;
                readWord[`LRC_ST_DTKNOWN] = s.dtKnown;
                readWord[`LRC_ST_CTRL] = s.rxCtrl;
                readWord[`LRC_ST_WORDS +: `LRC_WORDS] = s.rxWords;
                readWord[`LRC_ST_KEYREQ] = s.keyRequest;
            end
            `LRC_OFS_KEYDATA: begin
                readWord[`LRC_KEY_W-1:0] = s.keyBuffer;
            end
            `LRC_OFS_CONFIG: begin
                readWord[`LRC_CFG_INHIBIT] = s.scanInhibit;
            end
            default: begin
                readWord = 32'h0;
            end
        endcase
    endfunction

    lrc_pkg::lrc_state_t st;
    lrc_pkg::lrc_state_t next_st;
    lrc_pkg::lrc_phase_t phase;
    logic [`LRC_FRAME_W-1:0] linkShift;
    logic [`LRC_WORD_W-1:0] payload;
    logic [`LRC_INDEX_W-1:0] frameIdx;
    logic [`LRC_WORD_W-1:0] seg;
    logic frameEnd;
    logic sysReset;
    logic releaseNow;
    logic mapped;

    // ************************************************************
    // Link clock domain
    // ************************************************************

    // The shifter only moves while enable is high, so its contents stand
    // still once the frame is over; the system side samples it then.
    always_ff @(posedge serialClock or negedge reset_n) begin
        if (!reset_n) begin
            linkShift <= '0;
        end else if (serialEnable) begin
            linkShift <= {linkShift[`LRC_FRAME_W-2:0], serialData}; // R9
        end
    end

    // Payload sits above the word index, which is sent last.
    assign payload = linkShift[`LRC_FRAME_W-1:`LRC_INDEX_W];
    assign frameIdx = linkShift[`LRC_INDEX_W-1:0];

    // ************************************************************
    // Reset phase
    // ************************************************************

    // The detector sets the phase at once, without a clock; the hold can
    // only end on a frame end seen after the detector has let go.
    always_ff @(posedge clock or negedge reset_n or posedge supplyDropResetDetect) begin
        if (!reset_n) begin
            phase <= lrc_pkg::LRC_HELD; // R1
        end else if (supplyDropResetDetect) begin
            phase <= lrc_pkg::LRC_HELD; // R2 R19
        end else if (releaseNow) begin
            phase <= lrc_pkg::LRC_RUNNING; // R3 R19
        end
    end

    assign sysReset = (phase == lrc_pkg::LRC_HELD);
    assign frameEnd = st.enPrev & ~st.enSync2;
    assign mapped = (haddr[31:`LRC_ADDR_W] == '0) && (hsize == `LRC_HSIZE_WORD);

    // ************************************************************
    // System clock domain
    // ************************************************************

    // Next state of the whole domain; later assignments take priority.
    always_comb begin
        next_st = st;
        releaseNow = 1'b0;
        next_st.enSync1 = serialEnable;
        next_st.enSync2 = st.enSync1;
        next_st.enPrev = st.enSync2;
        next_st.dropSync1 = supplyDropResetDetect;
        next_st.dropSync2 = st.dropSync1;
        next_st.oscSync1 = oscPinIn;
        next_st.oscSync2 = st.oscSync1;
        next_st.keySync1 = keyReturn;
        next_st.keySync2 = st.keySync1;
        // Frames are taken whatever the reset phase is.
        if (frameEnd) begin
            if (frameIdx <= `LRC_IDX_DISP_MAX) begin
                next_st.latch[frameIdx[1:0]] = payload; // R6 R9
                next_st.rxWords[frameIdx[1:0]] = 1'b1;
            end else if (frameIdx == `LRC_IDX_CTRL) begin
                next_st.dutySelect = payload[`LRC_CB_DUTY]; // R13
                next_st.clockSourceSelect = payload[`LRC_CB_CLKSRC]; // R16
                next_st.keyScanDisable = payload[`LRC_CB_SCANOFF];
                next_st.keyscanSegMode = payload[`LRC_CB_KSSEG];
                next_st.gpoMode = payload[`LRC_CB_GPO +: `LRC_GPO_W];
                next_st.dtKnown = 1'b1;
                next_st.rxCtrl = 1'b1;
            end
            // The check uses the duty of the frame just ended.
            releaseNow = !st.dropSync2 && next_st.rxCtrl && ((next_st.rxWords
                & wordsNeeded(next_st.dutySelect)) == wordsNeeded(next_st.dutySelect)); // R3 R4
        end
        // After a supply drop the whole set has to be sent again.
        if (st.dropSync2) begin
            next_st.rxWords = '0;
            next_st.rxCtrl = 1'b0;
        end
        // Key capture; a press is taken only while no read is pending.
        if (sysReset || !keyScanEnabled) begin
            next_st.keyBuffer = '0; // R7 R8
            next_st.keyRequest = 1'b0; // R15
        end else if (frameEnd && frameIdx == `LRC_IDX_KEYREAD) begin
            next_st.keyRequest = 1'b0;
        end else if (!st.keyRequest && (|st.keySync2)) begin
            next_st.keyBuffer = st.keySync2;
            next_st.keyRequest = 1'b1; // R18
        end
        next_st.oscToggle = oscRunEnable ? ~st.oscToggle : 1'b0; // R5
        // Bus: a write lands in its data phase, a read is fetched at once.
        next_st.wrPending = 1'b0;
        if (st.wrPending && st.wrAddr == `LRC_OFS_CONFIG) begin
            next_st.scanInhibit = hwdata[`LRC_CFG_INHIBIT];
        end
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                next_st.wrPending = 1'b1;
                next_st.wrAddr = mapped ? haddr[`LRC_ADDR_W-1:0] : `LRC_OFS_NONE;
            end else begin
                next_st.rdata = readWord(mapped ? haddr[`LRC_ADDR_W-1:0]
                    : `LRC_OFS_NONE, st, sysReset);
            end
        end
    end

    // Chip reset only; the serial side and control survive system reset.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.dutySelect <= `LRC_DUTY_RST;
            st.clockSourceSelect <= `LRC_CLKSRC_RST;
        end else begin
            st <= next_st; // R9
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Pins follow the phase flop directly so a drop reaches them at once.
    assign seg = st.latch[0];
    assign systemReset = sysReset;
    assign displayOn = !sysReset; // R6 R17
    assign keyScanEnabled = !sysReset && !st.keyScanDisable && !st.scanInhibit; // R7 R17
    assign segGpoShared = displayOn ? seg[`LRC_SEG_GPO_LO +: `LRC_GPO_W] : '0; // R10
    assign segGpoIsSegment = sysReset ? '1 : ~st.gpoMode; // R10
    assign dedicatedSegmentOut = displayOn ? seg[`LRC_SEG_DED_LO +: `LRC_SEG_DED_N] : '0; // R11
    assign commonOut = displayOn ? '1 : '0; // R11
    assign common4IsCommon = !st.dtKnown || st.dutySelect; // R12 R13
    assign common4Seg39Shared = displayOn && (common4IsCommon || seg[`LRC_SEG_COM4]); // R12
    assign keyscanIsSegment = sysReset || st.keyscanSegMode; // R10
    // In scan mode the shared pins carry the scan drive level.
    assign keyscanSegShared = sysReset ? '0 : (keyscanIsSegment
        ? seg[`LRC_SEG_KS_LO +: `LRC_KS_N] : {`LRC_KS_N{keyScanEnabled}}); // R10
    assign keyscanOutDedicated = {`LRC_KS_N{keyScanEnabled}}; // R11
    assign oscRunEnable = !sysReset && !st.clockSourceSelect; // R5 R16
    assign extClockEnable = !sysReset && st.clockSourceSelect; // R5 R16
    assign oscPinOe = oscRunEnable; // R14
    assign oscPinOut = st.oscToggle;
    assign gatedExtClock = extClockEnable && st.oscSync2;
    // Open drain: low only while a read is pending and no frame runs.
    assign keyRequestOut = 1'b0;
    assign keyRequestOe = st.keyRequest && !sysReset && !st.enSync2; // R15 R18
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;

    // ************************************************************
    // Assertions
    // ************************************************************

    property p_dropHolds;
        @(posedge clock) disable iff (!reset_n)
        supplyDropResetDetect |-> systemReset;
    endproperty
    a_dropHolds: assert property (p_dropHolds) // R1 R2
        else $error("Reset not held while supply is low.");

    property p_releaseAtFrameEnd;
        @(posedge clock) disable iff (!reset_n)
        $fell(systemReset) |-> $past(frameEnd) && !$past(st.dropSync2);
    endproperty
    a_releaseAtFrameEnd: assert property (p_releaseAtFrameEnd) // R3 R19
        else $error("Reset released away from a frame end.");

    property p_releaseNeedsSet;
        @(posedge clock) disable iff (!reset_n)
        $fell(systemReset) |-> st.rxCtrl
            && ((st.rxWords & wordsNeeded(st.dutySelect)) == wordsNeeded(st.dutySelect));
    endproperty
    a_releaseNeedsSet: assert property (p_releaseNeedsSet) // R4
        else $error("Reset released before the full data set.");

    // Judged on the flags after the frame, so the frame that completes the set
    // is the one that has to release; earlier frames leave the hold alone.
    property p_releaseWhenDone;
        @(posedge clock) disable iff (!reset_n)
        frameEnd && systemReset && !st.dropSync2 |=> !systemReset
            || supplyDropResetDetect || !st.rxCtrl || !(&st.rxWords[WORDS3-1:0])
            || (st.dutySelect && !(&st.rxWords[WORDS4-1:0]));
    endproperty
    a_releaseWhenDone: assert property (p_releaseWhenDone) // R3
        else $error("Complete set did not release reset.");

    property p_resetPins;
        @(posedge clock) disable iff (!reset_n)
        systemReset |-> segGpoShared == '0 && dedicatedSegmentOut == '0
            && commonOut == '0 && keyscanSegShared == '0 && keyscanOutDedicated == '0
            && (&segGpoIsSegment) && keyscanIsSegment && !oscPinOe
            && !oscRunEnable && !extClockEnable && !keyRequestOe;
    endproperty
    a_resetPins: assert property (p_resetPins) // R5 R10 R11 R14 R15
        else $error("Pin or clock not in reset state.");

    property p_latchInReset;
        @(posedge clock) disable iff (!reset_n)
        frameEnd && frameIdx == 3'h0 |=> st.latch[0] == $past(payload);
    endproperty
    a_latchInReset: assert property (p_latchInReset) // R6 R9
        else $error("Display word not latched.");

    property p_keyClear;
        @(posedge clock) disable iff (!reset_n)
        systemReset && $past(systemReset) |-> st.keyBuffer == '0
            && !st.keyRequest && !keyScanEnabled;
    endproperty
    a_keyClear: assert property (p_keyClear) // R7 R8
        else $error("Key scan or buffer active in reset.");

    property p_firstCommon;
        @(posedge clock) disable iff (!reset_n)
        !st.dtKnown |-> common4IsCommon;
    endproperty
    a_firstCommon: assert property (p_firstCommon) // R12
        else $error("Fourth common pin not common before duty known.");

    property p_dutyPin;
        @(posedge clock) disable iff (!reset_n)
        frameEnd && frameIdx == `LRC_IDX_CTRL |=> ##1
            common4IsCommon == $past(payload[`LRC_CB_DUTY], 2);
    endproperty
    a_dutyPin: assert property (p_dutyPin) // R13
        else $error("Fourth common pin ignores duty bit.");

    property p_clockSelect;
        @(posedge clock) disable iff (!reset_n)
        frameEnd && frameIdx == `LRC_IDX_CTRL |=> systemReset
            || (extClockEnable == $past(payload[`LRC_CB_CLKSRC])
            && oscRunEnable != extClockEnable);
    endproperty
    a_clockSelect: assert property (p_clockSelect) // R16
        else $error("Clock source does not follow select bit.");

    property p_displayOnAtRelease;
        @(posedge clock) disable iff (!reset_n)
        $fell(systemReset) |-> displayOn
            && keyScanEnabled == (!st.keyScanDisable && !st.scanInhibit);
    endproperty
    a_displayOnAtRelease: assert property (p_displayOnAtRelease) // R17
        else $error("Display or scan not enabled at release.");

    property p_keyRequest;
        @(posedge clock) disable iff (!reset_n)
        $rose(st.keyRequest) |-> st.keyBuffer == $past(st.keySync2)
            && (keyRequestOe || st.enSync2);
    endproperty
    a_keyRequest: assert property (p_keyRequest) // R18
        else $error("Key request not signalled with captured data.");

endmodule
`default_nettype wire

// >>> lrc_link_ctrl.sv
// Behavioural model of the system controller that drives the serial link.
// Assumes the frame layout of lrc_params.svh: payload MSB first, then index.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_params.svh"

// ****************************************************************
// Serial controller model
// ****************************************************************
module lrc_link_ctrl #(
    parameter int HALF = 15
) (
    output logic serialClock,
    output logic serialEnable,
    output logic serialData
);
    // The link clock stands still low outside frames.
    initial begin
        serialClock = 1'b0;
        serialEnable = 1'b0;
        serialData = 1'b0;
    end

    // One whole frame; data changes only while the link clock is low.
    task automatic send(input logic [2:0] idx, input logic [`LRC_WORD_W-1:0] pl);
        logic [`LRC_FRAME_W-1:0] f;
        f = {pl, idx};
        serialEnable = 1'b1;
        for (int i = `LRC_FRAME_W - 1; i >= 0; i--) begin
            serialData = f[i];
            #HALF serialClock = 1'b1;
            #HALF serialClock = 1'b0;
        end
        #HALF serialEnable = 1'b0;
        // A released data line shows no stale value, so invert it.
        serialData = ~serialData;
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// >>> tb_lrc_reset_control.sv
// Self-checking bench for the system reset control.
// Assumes the serial controller model and an AHB-Lite master made of tasks.
`timescale 1ns/1ps
`default_nettype none
`include "lrc_params.svh"

module tb_lrc_reset_control;
    logic clock = 1'b0, reset_n = 1'b0, supplyDrop = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic takeRd = 1'b0, takePin = 1'b0, oscIn = 1'b0;
    logic [`LRC_KEY_W-1:0] keyReturn = '0, key;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [63:0] rnd;
    logic [41:0] w0;
    logic [30:0] pv;
    logic [31:0] q[$];
    int mismatches = 0, n_tests = 0, seed = 67;
    wire logic sck, sen, sdat, hreadyout, hresp, c4s, c4c, ksIsSeg, oscOut, oscOe, oscRun;
    wire logic extEn, gExt, kReqOut, kReqOe, systemReset, displayOn, keyScanEnabled;
    wire logic [3:0] segGpo, segGpoIsSeg;
    wire logic [33:0] dedSeg;
    wire logic [2:0] com, ksSeg, ksDed;

    lrc_link_ctrl link (.serialClock(sck), .serialEnable(sen), .serialData(sdat));

    lrc_reset_control dut (.clock(clock), .reset_n(reset_n),
        .supplyDropResetDetect(supplyDrop), .serialClock(sck), .serialEnable(sen),
        .serialData(sdat), .keyReturn(keyReturn), .oscPinIn(oscIn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .segGpoShared(segGpo), .segGpoIsSegment(segGpoIsSeg), .dedicatedSegmentOut(dedSeg),
        .commonOut(com), .common4Seg39Shared(c4s), .common4IsCommon(c4c),
        .keyscanSegShared(ksSeg), .keyscanIsSegment(ksIsSeg), .keyscanOutDedicated(ksDed),
        .oscPinOut(oscOut), .oscPinOe(oscOe), .oscRunEnable(oscRun),
        .extClockEnable(extEn), .gatedExtClock(gExt), .keyRequestOut(kReqOut),
        .keyRequestOe(kReqOe), .systemReset(systemReset), .displayOn(displayOn),
        .keyScanEnabled(keyScanEnabled));

    // Pin snapshot compared against the expected pin picture.
    assign pv = {hresp, kReqOut, gExt, c4s, ksIsSeg, ksSeg, segGpo, segGpoIsSeg, com,
                 c4c, ksDed, oscOe, oscRun, extEn, kReqOe, systemReset, displayOn,
                 keyScanEnabled, |dedSeg};

    // ****************************************************************
    // Clock, checking and closing
    // ****************************************************************
    // Free-running system clock.
    initial forever #2 clock = ~clock;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Monitor takes the oldest note when a result is flagged; negedge keeps it race free.
    always @(negedge clock) begin
        if (takeRd) check(hrdata, q.pop_front());
        if (takePin) check({1'h0, pv}, q.pop_front());
    end

    // Expected pins: reset picture, or running picture for control byte c.
    function automatic logic [31:0] pe(input logic rs, c4, input logic [7:0] c,
        input logic kr, input logic [41:0] w);
        logic cs, sc, ks;
        cs = c[`LRC_CB_CLKSRC];
        sc = !c[`LRC_CB_SCANOFF];
        ks = c[`LRC_CB_KSSEG];
        if (rs) return {1'h0, 3'h0, 1'b0, 1'b1, 3'h0, 4'h0, 4'hf, 3'h0, c4, 3'h0, 4'h0, 4'h8};
        return {1'h0, 2'h0, cs, c4 | w[38], ks, ks ? w[41:39] : {3{sc}}, w[3:0],
            ~c[7:4], 3'h7, c4, {3{sc}}, !cs, !cs, cs, kr, 2'b01, sc, |w[37:4]};
    endfunction

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task snap(input logic [31:0] e);
        @(posedge clock);
        q.push_back(e);
        takePin <= 1'b1;
        @(posedge clock);
        takePin <= 1'b0;
    endtask

    // Bounded wait for hready at a rising edge.
    task rdy;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                mismatches++;
                stop_test;
            end
            @(posedge clock);
        end
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        if (!wr) begin
            q.push_back(e);
            takeRd <= 1'b1;
        end
        rdy;
        takeRd <= 1'b0;
    endtask

    task waitRel;
        int n;
        n = 0;
        while (systemReset !== 1'b0) begin
            @(posedge clock);
            n++;
            if (n > 40) begin
                mismatches++;
                stop_test;
            end
        end
    endtask

    // Hang guard well above the run time of the main sequence.
    initial begin
        #300000;
        mismatches++;
        stop_test;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rnd = {$random(seed), $random(seed)};
        w0 = rnd[41:0];
        key = rnd[59:30] | 30'h1;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        snap(pe(1'b1, 1'b1, 1'b0, 1'b0, w0));
        bus(1'b0, 32'h0, 32'h0, 32'h3);
        supplyDrop <= 1'b0;
        repeat (4) @(posedge clock);
        // Set for one-third duty sent while held; serial side is live in reset.
        link.send(3'h4, 42'h0);
        link.send(3'h0, w0);
        link.send(3'h1, 42'h0);
        repeat (10) @(posedge clock);
        snap(pe(1'b1, 1'b0, 1'b0, 1'b0, w0));
        link.send(3'h2, 42'h0);
        waitRel;
        snap(pe(1'b0, 1'b0, 1'b0, 1'b0, w0));
        bus(1'b0, 32'h0, 32'h0, 32'hf8);
        // Key press raises the request; a key read frame drops it.
        keyReturn <= key;
        repeat (10) @(posedge clock);
        snap(pe(1'b0, 1'b0, 1'b0, 1'b1, w0));
        bus(1'b0, 32'h4, 32'h0, {2'h0, key});
        keyReturn <= '0;
        link.send(3'h7, 42'h0);
        repeat (10) @(posedge clock);
        snap(pe(1'b0, 1'b0, 1'b0, 1'b0, w0));
        // Register map: config round trip, unmapped read, read-only write.
        bus(1'b1, 32'h8, 32'h1, 32'h0);
        bus(1'b0, 32'h8, 32'h0, 32'h1);
        bus(1'b0, 32'hc, 32'h0, 32'h0);
        bus(1'b1, 32'h0, 32'hffff, 32'h0);
        bus(1'b0, 32'h0, 32'h0, 32'hf8);
        bus(1'b1, 32'h8, 32'h0, 32'h0);
        // Supply drop with a read pending: immediate reset, buffer cleared.
        keyReturn <= key;
        repeat (10) @(posedge clock);
        snap(pe(1'b0, 1'b0, 1'b0, 1'b1, w0));
        supplyDrop <= 1'b1;
        snap(pe(1'b1, 1'b0, 1'b0, 1'b0, w0));
        link.send(3'h7, 42'h0);
        snap(pe(1'b1, 1'b0, 1'b0, 1'b0, w0));
        bus(1'b0, 32'h4, 32'h0, 32'h0);
        keyReturn <= '0;
        supplyDrop <= 1'b0;
        oscIn <= 1'b1;
        repeat (4) @(posedge clock);
        // Quarter duty needs the fourth word; external clock selected.
        link.send(3'h4, 42'h3);
        link.send(3'h0, w0);
        link.send(3'h1, 42'h0);
        link.send(3'h2, 42'h0);
        repeat (10) @(posedge clock);
        snap(pe(1'b1, 1'b1, 1'b1, 1'b0, w0));
        link.send(3'h3, 42'h0);
        waitRel;
        snap(pe(1'b0, 1'b1, 8'h3, 1'b0, w0));
        // Control rewritten while running: internal clock, scan off, pins remapped.
        link.send(3'h4, 42'hfd);
        snap(pe(1'b0, 1'b1, 8'hfd, 1'b0, w0));
        stop_test;
    end
endmodule
`default_nettype wire
